// file: charger_pkg.sv
// Shared constants and types for the charge cycle sequencer.
// Assumes a 125 MHz clock and an AXI4-Lite register port with 32-bit data.
package charger_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int GLITCH_NS     = 1000;
	localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Register map (byte addresses)
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  ADDR_CONFIG = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_TIMER  = 8'h08;
	localparam int          TIME_W      = 24;
	localparam logic [23:0] CHARGE_TIME_RST = 24'h002328;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_DECERR = 2'h3;

	// Status register fields
	localparam int ST_PHASE_LSB = 0;
	localparam int ST_OUT_BIT   = 4;
	localparam int ST_FAULT_BIT = 5;
	localparam int ST_DONE_BIT  = 6;
	localparam int ST_SUSP_BIT  = 7;
	localparam int ST_BATTERY_ABSENT_OUT_BIT = 8;

	// ==========================================================
	// Charge phases
	typedef enum logic [2:0] {
		PH_OFF      = 3'b000,
		PH_PRE      = 3'b001,
		PH_CC       = 3'b010,
		PH_CV       = 3'b011,
		PH_FLOAT    = 3'b100,
		PH_MONITOR  = 3'b101,
		PH_FAULT    = 3'b110,
		PH_REGULATE = 3'b111
	} phase_e;

	// Comparator flags from the analog section
	typedef struct packed {
		logic supply_ok;       // Supply above undervoltage lockout
		logic en_low;          // Enable/thermistor pin below disable level
		logic ntc_window;      // Thermistor level inside 30..75 % window
		logic ntc_open;        // Thermistor level above 95 %
		logic supply_ovp;      // Supply overvoltage
		logic die_hot;         // Die over temperature
		logic above_precharge; // Battery above pre-charge threshold
		logic at_float;        // Battery at float voltage
		logic below_recharge;  // Battery below float minus recharge margin
		logic below_term;      // Output current below termination level
		logic timer_off;       // Timer-select pin at ground
		logic regulator_sel;   // Timer-select pin at supply
	} flags_s;

	localparam int FLAG_W = $bits(flags_s);

endpackage

// file: flag_filter.sv
// Two-flop synchroniser plus stability filter for a vector of flags.
// Assumes raw flags may change at any time relative to aclk.
`timescale 1ns/1ps
module flag_filter #(
	parameter int W      = 1,
	parameter int STABLE = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] raw,
	output logic      [W-1:0] filt
);
	localparam int CW = $clog2(STABLE + 1);

	if (W < 1 || STABLE < 1) begin : g_chk
		$error("flag_filter: W and STABLE must be at least 1");
	end

	logic [W-1:0]         meta_q;
	logic [W-1:0]         sync_q;
	logic [W-1:0]         filt_q;
	logic [W-1:0]         filt_d;
	logic [W-1:0][CW-1:0] cnt_q;
	logic [W-1:0][CW-1:0] cnt_d;

	// ==========================================================
	// Accept a new level only after it stood STABLE cycles
	always_comb begin
		for (int i = 0; i < W; i++) begin
			filt_d[i] = filt_q[i];
			cnt_d[i]  = '0;
			if (sync_q[i] != filt_q[i]) begin
				if (cnt_q[i] >= CW'(STABLE - 1)) begin
					filt_d[i] = sync_q[i];
				end else begin
					cnt_d[i] = cnt_q[i] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			sync_q <= '0;
			filt_q <= '0;
			cnt_q  <= '0;
		end else begin
			meta_q <= raw;
			sync_q <= meta_q;
			filt_q <= filt_d;
			cnt_q  <= cnt_d;
		end
	end

	assign filt = filt_q;

endmodule

// file: charge_cycle_sequencer.sv
// Charge cycle sequencer for a single-cell lithium-ion charger.
// Assumes comparator flags from the analog section and an AXI4-Lite master.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps

// Behaviour
// - Glitch-filter the supply flag; start a cycle only above undervoltage lockout.
// - Drive the status output low when a charge cycle starts.
// - Battery below pre-charge threshold selects the pre-charge phase.
// - Battery above pre-charge threshold, below float, selects constant current.
// - Battery at float voltage moves constant current to constant voltage.
// - Current below termination drives the status output high.
// - Timer enabled: float charge after termination until expiry, then output off.
// - Timer disabled: output off at once on termination.
// - Regulator mode keeps output on; termination never turns it off. The code still turns it off on supply overvoltage or die over temperature.
// - After completion monitor with output off; restart on recharge sag.
// - Pre-charge longer than a quarter of charge time: output off, fault.
// - Enable or supply toggle, or battery above threshold, clears pre-charge fault.
// - Low enable/thermistor level disables the whole device.
// - Thermistor level in the 30..75 percent window allows charging.
// - Thermistor level above 95 percent drives the battery-absent output high.
// - Timer-select at ground disables the timer; termination acts immediately.
// - Timer-select at supply selects regulator mode with timer disabled.
// - Out-of-window temperature suspends outside regulator mode: output off, timer frozen, status blinking.
// - Charge timer counts only while the output is on.
// - Status output floats in undervoltage; blinks in pre-charge and faults.
// - Recharge from monitor mode clears the charge timer first.
module charge_cycle_sequencer #(
	parameter int TICK_CYCLES  = 125_000_000,
	parameter int BLINK_CYCLES = 62_500_000
) (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire charger_pkg::flags_s       flags_in,
	input  wire logic [charger_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [charger_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic                           output_on,
	output logic                           charge_status_out,
	output logic                           charge_status_oe,
	output logic                           battery_absent_out,
	output logic                           precharge_fault_out
);
	import charger_pkg::*;

	if (TICK_CYCLES < 2 || BLINK_CYCLES < 2) begin : g_chk
		$error("charge_cycle_sequencer: divider counts must be at least 2");
	end

	// ==========================================================
	// Flag synchronisation and supply glitch filter
	flags_s                 f;
	logic [FLAG_W-2:0]      rest_f;
	logic                   supply_f;

	flag_filter #(.W(1), .STABLE(GLITCH_CYCLES)) u_supply_filter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw     (flags_in.supply_ok),
		.filt    (supply_f)
	);

	flag_filter #(.W(FLAG_W - 1), .STABLE(1)) u_flag_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw     (flags_in[FLAG_W-2:0]),
		.filt    (rest_f)
	);

	assign f = flags_s'({supply_f, rest_f});

	// ==========================================================
	// Tick and blink dividers
	logic [31:0] tick_cnt_q, tick_cnt_d, blink_cnt_q, blink_cnt_d;
	logic        tick_q, tick_d, blink_q, blink_d;

	always_comb begin
		tick_d      = (tick_cnt_q == 32'(TICK_CYCLES - 1));
		tick_cnt_d  = tick_d ? '0 : tick_cnt_q + 32'h0000_0001;
		blink_cnt_d = (blink_cnt_q == 32'(BLINK_CYCLES - 1)) ? '0 : blink_cnt_q + 32'h0000_0001;
		blink_d     = (blink_cnt_q == 32'(BLINK_CYCLES - 1)) ? ~blink_q : blink_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_q  <= '0;
			tick_q      <= 1'b0;
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
		end else begin
			tick_cnt_q  <= tick_cnt_d;
			tick_q      <= tick_d;
			blink_cnt_q <= blink_cnt_d;
			blink_q     <= blink_d;
		end
	end

	// ==========================================================
	// Charge sequencer
	phase_e            phase_q, phase_d;
	logic [TIME_W-1:0] timer_q, timer_d, cfg_time_q, cfg_time_d;
	logic              done_q, done_d, susp_q, out_d, stat_d, oe_d;
	logic              enabled, suspend, timer_use, expired, pre_limit;

	assign enabled   = f.supply_ok & ~f.en_low;
	assign suspend   = (~f.regulator_sel & ~f.ntc_window)
	                 | f.supply_ovp | f.die_hot;
	assign timer_use = ~f.timer_off & ~f.regulator_sel;
	assign expired   = timer_use & (timer_q >= cfg_time_q);
	assign pre_limit = timer_use & (timer_q >= (cfg_time_q >> 2));

	always_comb begin
		phase_d = phase_q;
		done_d  = done_q;
		timer_d = timer_q + TIME_W'(tick_q & output_on);
		if (!enabled) begin
			phase_d = PH_OFF;
			done_d  = 1'b0;
			timer_d = '0;
		end else if (f.regulator_sel != (phase_q == PH_REGULATE) && phase_q != PH_OFF) begin
			phase_d = PH_OFF;
		end else if (!suspend) begin
			case (phase_q)
				PH_OFF: begin
					timer_d = '0;
					done_d  = 1'b0;
					if (f.regulator_sel) begin
						phase_d = PH_REGULATE;
					end else begin
						phase_d = f.above_precharge ? PH_CC : PH_PRE;
					end
				end
				PH_PRE: begin
					if (f.above_precharge) begin
						phase_d = PH_CC;
					end else if (pre_limit) begin
						phase_d = PH_FAULT;
					end
				end
				PH_CC: begin
					if (!f.above_precharge) begin
						phase_d = PH_PRE;
					end else if (f.at_float) begin
						phase_d = PH_CV;
					end else if (expired) begin
						phase_d = PH_MONITOR;
					end
				end
				PH_CV: begin
					if (f.below_term) begin
						done_d  = 1'b1;
						phase_d = timer_use ? PH_FLOAT : PH_MONITOR;
					end else if (expired) begin
						phase_d = PH_MONITOR;
					end
				end
				PH_FLOAT: begin
					if (expired) begin
						phase_d = PH_MONITOR;
					end
				end
				PH_MONITOR: begin
					if (f.below_recharge) begin
						timer_d = '0;
						done_d  = 1'b0;
						phase_d = f.above_precharge ? PH_CC : PH_PRE;
					end
				end
				PH_FAULT: begin
					if (f.above_precharge) begin
						phase_d = PH_CC;
					end
				end
				PH_REGULATE: begin
					done_d = f.below_term;
				end
				default: begin
					phase_d = PH_OFF;
				end
			endcase
		end
		out_d = enabled & ~suspend & (phase_d inside {PH_PRE, PH_CC, PH_CV, PH_FLOAT, PH_REGULATE});
		oe_d  = enabled;
		if (suspend || phase_d == PH_PRE || phase_d == PH_FAULT) begin
			stat_d = blink_q;
		end else begin
			stat_d = done_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_q             <= PH_OFF;
			done_q              <= 1'b0;
			timer_q             <= '0;
			susp_q              <= 1'b0;
			output_on           <= 1'b0;
			charge_status_out   <= 1'b0;
			charge_status_oe    <= 1'b0;
			battery_absent_out  <= 1'b0;
			precharge_fault_out <= 1'b0;
		end else begin
			phase_q             <= phase_d;
			done_q              <= done_d;
			timer_q             <= timer_d;
			susp_q              <= suspend;
			output_on           <= out_d;
			charge_status_out   <= stat_d;
			charge_status_oe    <= oe_d;
			battery_absent_out  <= f.ntc_open;
			precharge_fault_out <= (phase_d == PH_FAULT);
		end
	end

	// ==========================================================
	// AXI4-Lite slave
	logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
	logic [31:0]       w_data_q, w_data_d, rdata_d, status_word;
	logic [3:0]        w_strb_q, w_strb_d;
	logic              aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic              awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0]        bresp_d, rresp_d;
	logic [ADDR_W-1:0] wa, ra;

	assign wa = {aw_addr_q[ADDR_W-1:2], 2'b00};
	assign ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};

	always_comb begin
		status_word = '0;
		status_word[ST_PHASE_LSB +: 3] = phase_q;
		status_word[ST_OUT_BIT]        = output_on;
		status_word[ST_FAULT_BIT]      = precharge_fault_out;
		status_word[ST_DONE_BIT]       = done_q;
		status_word[ST_SUSP_BIT]       = susp_q;
		status_word[ST_BATTERY_ABSENT_OUT_BIT]      = battery_absent_out;
	end

	always_comb begin
		aw_full_d  = aw_full_q;
		aw_addr_d  = aw_addr_q;
		w_full_d   = w_full_q;
		w_data_d   = w_data_q;
		w_strb_d   = w_strb_q;
		bvalid_d   = s_axi_bvalid & ~s_axi_bready;
		bresp_d    = s_axi_bresp;
		cfg_time_d = cfg_time_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (aw_full_q && w_full_q && !s_axi_bvalid) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = RESP_OKAY;
			if (wa == ADDR_CONFIG) begin
				for (int b = 0; b < 3; b++) begin
					if (w_strb_q[b]) begin
						cfg_time_d[8*b +: 8] = w_data_q[8*b +: 8];
					end
				end
			end else if (wa != ADDR_STATUS && wa != ADDR_TIMER) begin
				bresp_d = RESP_DECERR;
			end
		end
		awready_d = ~aw_full_d;
		wready_d  = ~w_full_d;
		arready_d = s_axi_arready;
		rvalid_d  = s_axi_rvalid;
		rdata_d   = s_axi_rdata;
		rresp_d   = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d  = 1'b1;
			arready_d = 1'b0;
			rresp_d   = RESP_OKAY;
			case (ra)
				ADDR_CONFIG: rdata_d = {8'h00, cfg_time_q};
				ADDR_STATUS: rdata_d = status_word;
				ADDR_TIMER:  rdata_d = {8'h00, timer_q};
				default: begin
					rdata_d = '0;
					rresp_d = RESP_DECERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q     <= 1'b0;
			aw_addr_q     <= '0;
			w_full_q      <= 1'b0;
			w_data_q      <= '0;
			w_strb_q      <= '0;
			cfg_time_q    <= CHARGE_TIME_RST;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			aw_full_q     <= aw_full_d;
			aw_addr_q     <= aw_addr_d;
			w_full_q      <= w_full_d;
			w_data_q      <= w_data_d;
			w_strb_q      <= w_strb_d;
			cfg_time_q    <= cfg_time_d;
			s_axi_awready <= awready_d;
			s_axi_wready  <= wready_d;
			s_axi_bvalid  <= bvalid_d;
			s_axi_bresp   <= bresp_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid  <= rvalid_d;
			s_axi_rdata   <= rdata_d;
			s_axi_rresp   <= rresp_d;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic go;
	assign go = enabled & ~suspend & ~f.regulator_sel & (phase_q != PH_REGULATE);

	// Output off and no phase logic about to clear the timer
	logic hold;
	assign hold = enabled & ~output_on & (phase_q != PH_OFF)
	            & ~((phase_q == PH_MONITOR) & f.below_recharge);

	supply_undervoltage_lockout_gate_a: assert property (!f.supply_ok |=> phase_q == PH_OFF && !output_on)
		else $error("cycle running without supply");
	start_low_a: assert property (phase_q == PH_CC && !susp_q |-> charge_status_oe && !charge_status_out)
		else $error("status not low while charging");
	pre_select_a: assert property (go && phase_q == PH_CC && !f.above_precharge |=> phase_q == PH_PRE)
		else $error("pre-charge not selected");
	cc_select_a: assert property (go && phase_q == PH_PRE && f.above_precharge |=> phase_q == PH_CC)
		else $error("fast charge not selected");
	cv_select_a: assert property (go && phase_q == PH_CC && f.above_precharge && f.at_float |=> phase_q == PH_CV)
		else $error("constant voltage not selected");
	term_high_a: assert property (go && phase_q == PH_CV && f.below_term |=> charge_status_out && done_q)
		else $error("status not high on termination");
	term_off_a: assert property (go && phase_q == PH_CV && f.below_term && f.timer_off |=> !output_on && phase_q == PH_MONITOR)
		else $error("output on after termination with timer off");
	float_hold_a: assert property (go && phase_q == PH_FLOAT && !expired |=> output_on && phase_q == PH_FLOAT)
		else $error("float charge ended early");
	regulate_on_a: assert property (phase_q == PH_REGULATE && enabled && !suspend && f.regulator_sel |=> output_on)
		else $error("regulator output off");
	pre_fault_a: assert property (go && phase_q == PH_PRE && !f.above_precharge && pre_limit |=> precharge_fault_out && !output_on)
		else $error("pre-charge timeout not flagged");
	timer_freeze_a: assert property (hold && phase_q == $past(phase_q) |=> timer_q == $past(timer_q))
		else $error("timer advanced with output off");
	supply_undervoltage_lockout_hiz_a: assert property (!f.supply_ok |=> !charge_status_oe)
		else $error("status driven in undervoltage");
	battery_absent_out_a: assert property (f.ntc_open |=> battery_absent_out)
		else $error("battery absent not reported");

	pre_to_cc_c: cover property (phase_q == PH_PRE ##1 phase_q == PH_CC);
	cv_to_float_c: cover property (phase_q == PH_CV ##1 phase_q == PH_FLOAT);
	recharge_c: cover property (phase_q == PH_MONITOR ##1 phase_q inside {PH_PRE, PH_CC});
	fault_c: cover property (phase_q == PH_PRE ##1 phase_q == PH_FAULT);

endmodule

// file: battery_pack_model.sv
// Battery pack, thermistor divider and timer-select pin, seen as comparator flags.
// Assumes the bench sets the analog levels just after a rising clock edge.
`timescale 1ns/1ps
module battery_pack_model (
	input  wire logic         adapter_on,
	input  wire logic [6:0]   ntc_pct,
	input  wire logic [12:0]  vbat_mv,
	input  wire logic [10:0]  iout_ma,
	input  wire logic [1:0]   tsel,
	input  wire logic [1:0]   stress,
	output charger_pkg::flags_s flags
);
	import charger_pkg::*;

	// ==========================================================
	// Analog levels to comparator flags
	always_comb begin
		flags                 = '0;
		flags.supply_ok       = adapter_on;
		flags.en_low          = ntc_pct < 7'h16;
		flags.ntc_window      = ntc_pct >= 7'h1E && ntc_pct <= 7'h4B;
		flags.ntc_open        = ntc_pct > 7'h5F;
		flags.above_precharge = vbat_mv > 13'h0AF0;
		flags.at_float        = vbat_mv >= 13'h1068;
		flags.below_recharge  = vbat_mv < 13'h1004;
		flags.below_term      = iout_ma < 11'h032;
		flags.timer_off       = tsel == 2'h0;
		flags.regulator_sel   = tsel == 2'h3;
		flags.supply_ovp      = stress[0];
		flags.die_hot         = stress[1];
	end
endmodule

// file: charge_cycle_sequencer_test.sv
// Self-checking bench for the charge cycle sequencer over AXI4-Lite.
// Assumes the battery pack model stands in for the analog section.
`timescale 1ns/1ps
module charge_cycle_sequencer_test;
	import charger_pkg::*;

	localparam int BLINK = 4;
	logic              aclk, aresetn, adapter_on;
	flags_s            flags;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, d, e;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, r, tsel, stress;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic              output_on, cs_out, cs_oe, absent, fault;
	logic [6:0]        ntc_pct;
	logic [12:0]       vbat_mv;
	logic [10:0]       iout_ma;
	int                num_errors, checks_done;

	battery_pack_model battery_pack_model_inst (.adapter_on(adapter_on), .ntc_pct(ntc_pct),
		.vbat_mv(vbat_mv), .iout_ma(iout_ma), .tsel(tsel), .stress(stress), .flags(flags));

	charge_cycle_sequencer #(.TICK_CYCLES(4), .BLINK_CYCLES(BLINK)) charge_cycle_sequencer_inst (
		.aclk(aclk), .aresetn(aresetn), .flags_in(flags),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.output_on(output_on), .charge_status_out(cs_out), .charge_status_oe(cs_oe),
		.battery_absent_out(absent), .precharge_fault_out(fault));

	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bit aw, w;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		aw = 0;
		w = 0;
		while (!(aw && w)) begin
			@(posedge aclk);
			aw |= awvalid & awready;
			w |= wvalid & wready;
			awvalid <= !aw;
			wvalid  <= !w;
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic phase_is(input logic [2:0] p);
		rd(ADDR_STATUS, d);
		chk(32'(d[2:0]), 32'(p));
	endtask

	task automatic wait_out(input logic v);
		for (int i = 0; i < 400 && output_on !== v; i++) @(negedge aclk);
		chk(32'(output_on), 32'(v));
	endtask

	task automatic env(input logic a, input logic [6:0] n, input logic [12:0] b,
		input logic [10:0] i, input logic [1:0] t);
		@(posedge aclk);
		adapter_on <= a;
		ntc_pct    <= n;
		vbat_mv    <= b;
		iout_ma    <= i;
		tsel       <= t;
		repeat (8) @(negedge aclk);
	endtask

	task automatic blink_chk();
		logic s;
		@(negedge aclk);
		s = cs_out;
		repeat (BLINK) @(negedge aclk);
		chk(32'({cs_oe, cs_out}), 32'({1'b1, ~s}));
	endtask

	task automatic conclude();
		$display("Checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// Clock, watchdog and tests
	initial begin
		aclk = 0;
		forever #4 aclk = ~aclk;
	end

	initial begin
		#320000;
		num_errors++;
		conclude();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, adapter_on} = '0;
		{awaddr, araddr, wdata, tsel, stress} = '0;
		wstrb = 4'hF;
		ntc_pct = 7'h32;
		vbat_mv = 13'h09C4;
		iout_ma = 11'h1F4;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk(32'({output_on, cs_oe, absent, fault, bvalid, rvalid, awready, arready}), 32'h3);
		rd(ADDR_CONFIG, d);
		chk(d, 32'h00002328);
		rd(8'h0C, d);
		chk({d[29:0], r}, {30'h0, RESP_DECERR});
		wr(8'h0C, 32'h1);
		chk(32'(r), 32'(RESP_DECERR));
		wr(ADDR_STATUS, 32'hFFFFFFFF);
		chk(32'(r), 32'(RESP_OKAY));
		rd(ADDR_STATUS, d);
		chk({d[29:0], r}, {30'h0, RESP_OKAY});
		wr(ADDR_CONFIG, 32'hFF000040);
		rd(ADDR_CONFIG, d);
		chk(d, 32'h00000040);
		env(1'b1, 7'h32, 13'h09C4, 11'h1F4, 2'h0);
		repeat (50) @(negedge aclk);
		chk(32'(output_on), 32'h0);
		env(1'b0, 7'h32, 13'h09C4, 11'h1F4, 2'h0);
		repeat (200) @(negedge aclk);
		chk(32'(output_on), 32'h0);
		env(1'b1, 7'h32, 13'h09C4, 11'h1F4, 2'h0);
		wait_out(1'b1);
		phase_is(PH_PRE);
		blink_chk();
		env(1'b1, 7'h32, 13'h0DAC, 11'h1F4, 2'h0);
		phase_is(PH_CC);
		chk(32'({cs_oe, cs_out}), 32'h2);
		env(1'b1, 7'h32, 13'h1068, 11'h1F4, 2'h0);
		phase_is(PH_CV);
		env(1'b1, 7'h32, 13'h1068, 11'h01E, 2'h0);
		wait_out(1'b0);
		chk(32'({cs_oe, cs_out}), 32'h3);
		phase_is(PH_MONITOR);
		env(1'b1, 7'h32, 13'h0FA0, 11'h1F4, 2'h1);
		wait_out(1'b1);
		phase_is(PH_CC);
		rd(ADDR_TIMER, d);
		chk(32'(d < 32'h4), 32'h1);
		env(1'b1, 7'h32, 13'h1068, 11'h1F4, 2'h1);
		phase_is(PH_CV);
		env(1'b1, 7'h50, 13'h1068, 11'h1F4, 2'h1);
		wait_out(1'b0);
		blink_chk();
		rd(ADDR_TIMER, d);
		repeat (40) @(negedge aclk);
		rd(ADDR_TIMER, e);
		chk(e, d);
		env(1'b1, 7'h32, 13'h1068, 11'h1F4, 2'h1);
		wait_out(1'b1);
		phase_is(PH_CV);
		env(1'b1, 7'h32, 13'h1068, 11'h01E, 2'h1);
		phase_is(PH_FLOAT);
		chk(32'({output_on, cs_out}), 32'h3);
		wait_out(1'b0);
		phase_is(PH_MONITOR);
		env(1'b1, 7'h0A, 13'h0FA0, 11'h1F4, 2'h1);
		chk(32'({output_on, cs_oe}), 32'h0);
		env(1'b1, 7'h32, 13'h09C4, 11'h1F4, 2'h1);
		wait_out(1'b1);
		phase_is(PH_PRE);
		repeat (150) @(negedge aclk);
		chk(32'({fault, output_on}), 32'h2);
		phase_is(PH_FAULT);
		env(1'b1, 7'h32, 13'h0BB8, 11'h1F4, 2'h1);
		wait_out(1'b1);
		chk(32'(fault), 32'h0);
		for (int k = 1; k < 3; k++) begin
			@(posedge aclk);
			stress <= 2'(k);
			wait_out(1'b0);
			blink_chk();
			@(posedge aclk);
			stress <= 2'h0;
			wait_out(1'b1);
		end
		env(1'b1, 7'h64, 13'h0BB8, 11'h01E, 2'h1);
		chk(32'(absent), 32'h1);
		env(1'b1, 7'h64, 13'h0BB8, 11'h01E, 2'h3);
		wait_out(1'b1);
		phase_is(PH_REGULATE);
		repeat (200) @(negedge aclk);
		chk(32'(output_on), 32'h1);
		env(1'b0, 7'h32, 13'h0BB8, 11'h1F4, 2'h1);
		wait_out(1'b0);
		chk(32'(cs_oe), 32'h0);
		conclude();
	end
endmodule
